// ===== include/issl_pkg.sv
// ==========================================================
// Shared constants and types of the serial slave engine
package issl_pkg;
  localparam int ISSL_BYTE_W = 8;
  localparam int ISSL_SYNC_STAGES = 3;
  localparam logic [3:0] ISSL_LAST_BIT = 4'h8;
  localparam logic [3:0] ISSL_CNT_RST = 4'h0;
  localparam logic [4:0] ISSL_TEN_HDR = 5'h1E;
  localparam logic [7:0] ISSL_ADDR_RST = 8'h00;
  localparam logic [7:0] ISSL_BUF_RST = 8'h00;
  localparam logic ISSL_CKP_RST = 1'b1;
  localparam logic ISSL_LINE_IDLE = 1'b1;

  // Engine phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_ACK,
    ST_SEND,
    ST_MACK
  } issl_state_t;

  // Meaning of the byte being shifted in
  typedef enum logic [1:0] {
    K_ADDR,
    K_LOW,
    K_DATA
  } issl_kind_t;
endpackage

// ===== include/issl_bus_if.sv
`timescale 1ns/100ps
// ==========================================================
// Cleaned bus levels and events, sampler to engine
interface issl_bus_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport sync (output scl, sda, scl_rise, scl_fall, start, stop);
  modport engine (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// ===== src/issl_bus_sync.sv
`timescale 1ns/100ps
// ==========================================================
// Pin sampler: three stages, edge and condition detection
module issl_bus_sync #(
  parameter int STAGES = issl_pkg::ISSL_SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  issl_bus_if.sync bus
);
  import issl_pkg::*;

  logic [1:0] pin_in;
  logic [1:0] lvl_reg;
  logic [1:0] lvl_next;
  logic [3:0] ev_reg;
  logic [3:0] ev_next;
  logic seen_low_reg;
  logic seen_low_next;

  if (STAGES < 3) begin : g_bad
    $error("issl_bus_sync needs at least three stages");
  end

  assign pin_in = {sda_i, scl_i};

  // Per pin chain; level moves once the last two agree
  for (genvar g = 0; g < 2; g++) begin : g_sync
    logic [STAGES-1:0] ff_reg;
    logic [STAGES-1:0] ff_next;
    always_comb begin
      ff_next = {ff_reg[STAGES-2:0], pin_in[g]};
      lvl_next[g] = lvl_reg[g];
      if (ff_reg[STAGES-1] == ff_reg[STAGES-2]) begin
        lvl_next[g] = ff_reg[STAGES-1];
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ff_reg <= '1;
      end else begin
        ff_reg <= ff_next;
      end
    end
  end

  // Edges, Start, Stop (Stop needs one SCL low first)
  always_comb begin
    ev_next[0] = ~lvl_reg[0] & lvl_next[0];
    ev_next[1] = lvl_reg[0] & ~lvl_next[0];
    ev_next[2] = lvl_reg[1] & ~lvl_next[1] & lvl_reg[0] & lvl_next[0];
    ev_next[3] = ~lvl_reg[1] & lvl_next[1] & lvl_reg[0] & lvl_next[0]
      & seen_low_reg;
    seen_low_next = seen_low_reg | ~lvl_next[0];
    if (ev_next[2] || ev_next[3]) begin
      seen_low_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_reg <= {ISSL_LINE_IDLE, ISSL_LINE_IDLE};
      ev_reg <= 4'h0;
      seen_low_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
      ev_reg <= ev_next;
      seen_low_reg <= seen_low_next;
    end
  end

  assign bus.scl = lvl_reg[0];
  assign bus.sda = lvl_reg[1];
  assign bus.scl_rise = ev_reg[0];
  assign bus.scl_fall = ev_reg[1];
  assign bus.start = ev_reg[2];
  assign bus.stop = ev_reg[3];
endmodule

// ===== src/issl_slave.sv
`timescale 1ns/100ps
// ==========================================================
// Serial slave engine: address match, receive, transmit

// Behaviour
// - First byte after Start compared with own address; match loads buffer, flag.
// - Address mismatch returns to idle silently: no flag, no buffer load.
// - Second 7-bit own address matched the same way; masks shape both compares.
// - In 7-bit mode the read/write bit takes no part in matching.
// - 10-bit high byte must be 11110, address bits 2:1, then zero.
// - After acking 10-bit high byte, update flag set and SCL held.
// - Low byte compared on all bits; flag and update flag set regardless.
// - Writing own address clears update flag, releasing SCL.
// - 10-bit read accepted only after an earlier full write match.
// - Matching address with write: status cleared, buffer loaded, acknowledged.
// - Address not acknowledged when buffer full or overflow; overwrite enable relaxes.
// - Interrupt flag set per byte; only software clears it.
// - Stretch enable holds SCL after each acked data or 7-bit write address byte until release bit.
// - Start sets start status, optional flag; Stop sets stop status, idles.
// - Address or data hold: flag, release bit cleared after 8th fall.
// - Ack-time status marks the acknowledge phase when hold modes enabled.
// - Flag set after 9th fall of acked byte; not after a NACK, except the 10-bit low byte.
// - Matching address with read: status set, buffer loaded, acknowledged.
// - After read ack, release bit cleared; buffer write loads shift register.
// - Transmit eight bits, SDA changing only while SCL is low.
// - Master ack latched on 9th rise; NACK idles, ACK stretches.
// - Transmit flag set on 9th falling edge of each byte.
// - Transmit collision with detection enabled sets flag and idles.
// - Without hold modes the acknowledge is generated in hardware.
// - Cleared release bit only pulls SCL once SCL is already low.
module issl_slave (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic own_addr_wr,
  input wire logic [issl_pkg::ISSL_BYTE_W-1:0] own_addr_wdata,
  input wire logic [issl_pkg::ISSL_BYTE_W-1:0] second_own_address,
  input wire logic [issl_pkg::ISSL_BYTE_W-1:0] address_mask_one,
  input wire logic [issl_pkg::ISSL_BYTE_W-1:0] address_mask_two,
  input wire logic ten_bit_mode,
  input wire logic stretch_enable,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic buffer_overwrite_enable,
  input wire logic start_irq_enable,
  input wire logic stop_irq_enable,
  input wire logic slave_collision_detect_enable,
  input wire logic ack_value_select,
  input wire logic ckp_set,
  input wire logic irq_clear,
  input wire logic buf_read,
  input wire logic buf_write,
  input wire logic [issl_pkg::ISSL_BYTE_W-1:0] buf_wdata,
  input wire logic ovf_clear,
  input wire logic bcl_clear,
  output logic [issl_pkg::ISSL_BYTE_W-1:0] own_address,
  output logic [issl_pkg::ISSL_BYTE_W-1:0] serial_buffer,
  output logic serial_irq_flag,
  output logic update_address_flag,
  output logic buffer_full_flag,
  output logic receive_overflow_flag,
  output logic clock_release_bit,
  output logic ack_time_status,
  output logic master_ack_status,
  output logic bus_collision_flag,
  output logic rw_status,
  output logic data_status,
  output logic start_status,
  output logic stop_status
);
  import issl_pkg::*;

  issl_bus_if bus_if ();

  issl_state_t st_reg;
  issl_state_t st_next;
  issl_kind_t kind_reg;
  issl_kind_t kind_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] serial_shift_reg;
  logic [7:0] shift_next;
  logic [7:0] own_address_reg;
  logic [7:0] own_next;
  logic [7:0] buf_reg;
  logic [7:0] buf_next;
  logic bf_reg;
  logic bf_next;
  logic ov_reg;
  logic ov_next;
  logic irq_reg;
  logic irq_next;
  logic ua_reg;
  logic ua_next;
  logic ckp_reg;
  logic ckp_next;
  logic ack_time_status_reg;
  logic ack_time_status_next;
  logic mack_reg;
  logic mack_next;
  logic bcl_reg;
  logic bcl_next;
  logic rw_reg;
  logic rw_next;
  logic da_reg;
  logic da_next;
  logic sbit_reg;
  logic sbit_next;
  logic pbit_reg;
  logic pbit_next;
  logic ack_reg;
  logic ack_next;
  logic hold_reg;
  logic hold_next;
  logic prior_reg;
  logic prior_next;
  logic sda_drv_reg;
  logic sda_drv_next;
  logic scl_drv_reg;
  logic scl_drv_next;
  logic ack_out;
  logic ovf_now;
  logic hi_ok;
  logic hit;
  logic keep;

  // Masked 7-bit compare, read/write bit excluded
  function automatic logic mask_match(
    input logic [7:0] rx,
    input logic [7:0] ref_a,
    input logic [7:0] mask
  );
    return ((rx[7:1] ^ ref_a[7:1]) & mask[7:1]) == 7'h00;
  endfunction

  // ========================================================
  // Pin sampling
  issl_bus_sync #(
    .STAGES(ISSL_SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .bus(bus_if.sync)
  );

  // Acknowledge value: software choice under hold, else hardware
  assign ack_out = hold_reg ? ~ack_value_select : ack_reg;
  assign ovf_now = ov_reg | (bf_reg & ~buffer_overwrite_enable);
  assign keep = ~bf_reg | buffer_overwrite_enable;

  // Address decode of the byte just shifted in
  always_comb begin
    hi_ok = serial_shift_reg[7:3] == ISSL_TEN_HDR
      && serial_shift_reg[2:1] == own_address_reg[2:1];
    if (ten_bit_mode) begin
      hit = hi_ok && (!serial_shift_reg[0] || prior_reg);
    end else begin
      hit = mask_match(serial_shift_reg, own_address_reg,
        address_mask_one)
        || mask_match(serial_shift_reg, second_own_address,
        address_mask_two);
    end
  end

  // ========================================================
  // Engine next state
  always_comb begin
    st_next = st_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    shift_next = serial_shift_reg;
    own_next = own_address_reg;
    buf_next = buf_reg;
    bf_next = bf_reg;
    ov_next = ov_reg;
    irq_next = irq_reg;
    ua_next = ua_reg;
    ckp_next = ckp_reg;
    ack_time_status_next = ack_time_status_reg;
    mack_next = mack_reg;
    bcl_next = bcl_reg;
    rw_next = rw_reg;
    da_next = da_reg;
    sbit_next = sbit_reg;
    pbit_next = pbit_reg;
    ack_next = ack_reg;
    hold_next = hold_reg;
    prior_next = prior_reg;

    // Software actions first, so hardware sets win
    if (irq_clear) begin
      irq_next = 1'b0;
    end
    if (buf_read) begin
      bf_next = 1'b0;
    end
    if (ovf_clear) begin
      ov_next = 1'b0;
    end
    if (bcl_clear) begin
      bcl_next = 1'b0;
    end
    if (ckp_set) begin
      ckp_next = 1'b1;
    end
    if (own_addr_wr) begin
      own_next = own_addr_wdata;
      ua_next = 1'b0;
    end
    if (buf_write && st_reg != ST_RECV) begin
      buf_next = buf_wdata;
      shift_next = buf_wdata;
      bf_next = 1'b1;
    end

    case (st_reg)
      ST_IDLE: begin
        cnt_next = ISSL_CNT_RST;
      end
      ST_RECV: begin
        if (bus_if.scl_rise) begin
          shift_next = {serial_shift_reg[6:0], bus_if.sda};
          cnt_next = cnt_reg + 4'h1;
        end else if (bus_if.scl_fall && cnt_reg == ISSL_LAST_BIT) begin
          hold_next = 1'b0;
          ack_next = ~ovf_now;
          st_next = ST_ACK;
          case (kind_reg)
            K_ADDR: begin
              if (!hit) begin
                st_next = ST_IDLE;
              end else begin
                rw_next = serial_shift_reg[0];
                da_next = 1'b0;
                hold_next = address_hold_enable;
                if (keep) begin
                  buf_next = serial_shift_reg;
                  bf_next = 1'b1;
                end
              end
            end
            K_LOW: begin
              prior_next = serial_shift_reg == own_address_reg;
              ack_next = prior_next & ~ovf_now;
              if (prior_next && keep) begin
                buf_next = serial_shift_reg;
                bf_next = 1'b1;
              end
            end
            default: begin
              da_next = 1'b1;
              hold_next = data_hold_enable;
              if (keep) begin
                buf_next = serial_shift_reg;
                bf_next = 1'b1;
              end else begin
                ov_next = 1'b1;
              end
            end
          endcase
          if (st_next == ST_ACK && hold_next) begin
            irq_next = 1'b1;
            ckp_next = 1'b0;
          end
          if (st_next == ST_ACK) begin
            ack_time_status_next = address_hold_enable | data_hold_enable;
          end
        end
      end
      ST_ACK: begin
        if (bus_if.scl_fall) begin
          ack_time_status_next = 1'b0;
          cnt_next = ISSL_CNT_RST;
          hold_next = 1'b0;
          if (ack_out || kind_reg == K_LOW) begin
            irq_next = 1'b1;
          end
          if (kind_reg == K_LOW) begin
            ua_next = 1'b1;
            kind_next = K_DATA;
            st_next = prior_reg ? ST_RECV : ST_IDLE;
          end else if (!ack_out) begin
            st_next = ST_IDLE;
          end else if (kind_reg == K_ADDR && ten_bit_mode && !rw_reg) begin
            ua_next = 1'b1;
            kind_next = K_LOW;
            st_next = ST_RECV;
          end else if (rw_reg) begin
            ckp_next = 1'b0;
            st_next = ST_SEND;
          end else begin
            kind_next = K_DATA;
            st_next = ST_RECV;
            if (stretch_enable) begin
              ckp_next = 1'b0;
            end
          end
        end
      end
      ST_SEND: begin
        if (bus_if.scl_rise && serial_shift_reg[7] && !bus_if.sda
          && slave_collision_detect_enable) begin
          bcl_next = 1'b1;
          st_next = ST_IDLE;
        end else if (bus_if.scl_fall) begin
          shift_next = {serial_shift_reg[6:0], 1'b1};
          cnt_next = cnt_reg + 4'h1;
          if (cnt_next == ISSL_LAST_BIT) begin
            bf_next = 1'b0;
            st_next = ST_MACK;
          end
        end
      end
      ST_MACK: begin
        if (bus_if.scl_rise) begin
          mack_next = bus_if.sda;
        end else if (bus_if.scl_fall) begin
          irq_next = 1'b1;
          cnt_next = ISSL_CNT_RST;
          if (!mack_reg) begin
            ckp_next = 1'b0;
            st_next = ST_SEND;
          end else begin
            st_next = ST_IDLE;
          end
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase

    // Bus conditions override the byte engine
    if (bus_if.start) begin
      sbit_next = 1'b1;
      pbit_next = 1'b0;
      if (start_irq_enable) begin
        irq_next = 1'b1;
      end
      ckp_next = ISSL_CKP_RST;
      hold_next = 1'b0;
      ack_time_status_next = 1'b0;
      kind_next = K_ADDR;
      cnt_next = ISSL_CNT_RST;
      st_next = ST_RECV;
    end else if (bus_if.stop) begin
      pbit_next = 1'b1;
      sbit_next = 1'b0;
      if (stop_irq_enable) begin
        irq_next = 1'b1;
      end
      prior_next = 1'b0;
      ack_time_status_next = 1'b0;
      st_next = ST_IDLE;
    end
  end

  // ========================================================
  // Pin drive: SDA for ack and data, SCL for stretching
  always_comb begin
    sda_drv_next = 1'b0;
    if (st_next == ST_ACK && st_reg == ST_ACK) begin
      sda_drv_next = ack_out;
    end else if (st_next == ST_SEND) begin
      sda_drv_next = ~shift_next[7];
    end
    scl_drv_next = (ua_next | (~ckp_next & st_next != ST_IDLE))
      & (~bus_if.scl | scl_drv_reg);
  end

  // ========================================================
  // State registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_IDLE;
      kind_reg <= K_ADDR;
      cnt_reg <= ISSL_CNT_RST;
      serial_shift_reg <= ISSL_BUF_RST;
      own_address_reg <= ISSL_ADDR_RST;
      buf_reg <= ISSL_BUF_RST;
      bf_reg <= 1'b0;
      ov_reg <= 1'b0;
      irq_reg <= 1'b0;
      ua_reg <= 1'b0;
      ckp_reg <= ISSL_CKP_RST;
      ack_time_status_reg <= 1'b0;
      mack_reg <= 1'b0;
      bcl_reg <= 1'b0;
      rw_reg <= 1'b0;
      da_reg <= 1'b0;
      sbit_reg <= 1'b0;
      pbit_reg <= 1'b0;
      ack_reg <= 1'b0;
      hold_reg <= 1'b0;
      prior_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      scl_drv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
      serial_shift_reg <= shift_next;
      own_address_reg <= own_next;
      buf_reg <= buf_next;
      bf_reg <= bf_next;
      ov_reg <= ov_next;
      irq_reg <= irq_next;
      ua_reg <= ua_next;
      ckp_reg <= ckp_next;
      ack_time_status_reg <= ack_time_status_next;
      mack_reg <= mack_next;
      bcl_reg <= bcl_next;
      rw_reg <= rw_next;
      da_reg <= da_next;
      sbit_reg <= sbit_next;
      pbit_reg <= pbit_next;
      ack_reg <= ack_next;
      hold_reg <= hold_next;
      prior_reg <= prior_next;
      sda_drv_reg <= sda_drv_next;
      scl_drv_reg <= scl_drv_next;
    end
  end

  // ========================================================
  // Outputs, open-drain pins pull low only
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~scl_drv_reg;
  assign sda_oe_n = ~sda_drv_reg;
  assign own_address = own_address_reg;
  assign serial_buffer = buf_reg;
  assign serial_irq_flag = irq_reg;
  assign update_address_flag = ua_reg;
  assign buffer_full_flag = bf_reg;
  assign receive_overflow_flag = ov_reg;
  assign clock_release_bit = ckp_reg;
  assign ack_time_status = ack_time_status_reg;
  assign master_ack_status = mack_reg;
  assign bus_collision_flag = bcl_reg;
  assign rw_status = rw_reg;
  assign data_status = da_reg;
  assign start_status = sbit_reg;
  assign stop_status = pbit_reg;
endmodule

// ===== dv/issl_slave_chk.sv
`timescale 1ns/100ps
// ==========================================================
// Port-level checks of the serial slave engine
module issl_slave_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic ckp_set,
  input wire logic own_addr_wr,
  input wire logic irq_clear,
  input wire logic address_hold_enable,
  input wire logic data_hold_enable,
  input wire logic slave_collision_detect_enable,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  input wire logic [7:0] serial_buffer,
  input wire logic serial_irq_flag,
  input wire logic update_address_flag,
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_flag,
  input wire logic clock_release_bit,
  input wire logic ack_time_status,
  input wire logic bus_collision_flag,
  input wire logic rw_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Clock holding
  AST_HOLD_AFTER_LOW: assert property ($fell(scl_oe_n) |-> !$past(scl_i))
    else $error("scl pulled while line high");
  AST_HOLD_CAUSE: assert property (!scl_oe_n |->
    !clock_release_bit || update_address_flag)
    else $error("scl held without cause");
  AST_CKP_RELEASE: assert property (
    ckp_set && !update_address_flag |=> scl_oe_n)
    else $error("scl not released after set");
  AST_UA_WRITE: assert property (own_addr_wr |=> !update_address_flag)
    else $error("update flag not cleared");

  // ==========================================================
  // Flags, status and SDA drive
  AST_IRQ_STICKY: assert property (
    serial_irq_flag && !irq_clear |=> serial_irq_flag)
    else $error("irq flag dropped by itself");
  AST_ACK_TIME_STATUS_MODE: assert property (ack_time_status |->
    address_hold_enable || data_hold_enable)
    else $error("ack time without hold mode");
  AST_RW_ADDR: assert property ($rose(rw_status) |-> serial_buffer[0])
    else $error("read status without read address");
  AST_OVF_CAUSE: assert property (
    $rose(receive_overflow_flag) |-> $past(buffer_full_flag))
    else $error("overflow without full buffer");
  AST_BCL_ENABLE: assert property (
    $rose(bus_collision_flag) |-> $past(slave_collision_detect_enable))
    else $error("collision flag while disabled");
  AST_SDA_ON_LOW: assert property ($changed(sda_oe_n) |-> !$past(scl_i))
    else $error("sda drive changed while scl high");

  // Main scenarios reached
  C_READ: cover property ($rose(rw_status));
  C_TEN: cover property ($rose(update_address_flag));
  C_HOLD: cover property ($rose(ack_time_status));
  C_BCL: cover property ($rose(bus_collision_flag));
endmodule

bind issl_slave issl_slave_chk issl_slave_chk_inst (.*);

// ===== dv/issl_master_model.sv
`timescale 1ns/100ps
// ==========================================================
// Open-drain bus master model, honours clock stretching
module issl_master_model #(
  parameter int HALF = 80
) (
  output logic scl_m,
  output logic sda_m,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic stuck
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stuck = 1'b0;
  end
  // Let SCL go, wait bounded for every holder to let go
  task automatic rel_scl();
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl_w !== 1'b1 && n < 30000) begin
      #10;
      n++;
    end
    if (n >= 30000) stuck = 1'b1;
  endtask
  // One SCL pulse: drive while low, sample mid high
  task automatic clk_bit(input logic drv, output logic smp);
    #(HALF/2) sda_m = drv;
    #(HALF/2) rel_scl();
    #(HALF/2) smp = sda_w;
    #(HALF/2) scl_m = 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    #(HALF/2) sda_m = 1'b1;
    #(HALF/2) rel_scl();
    #(HALF/2) sda_m = 1'b0;
    #(HALF/2) scl_m = 1'b0;
  endtask
  task automatic stop();
    #(HALF/2) sda_m = 1'b0;
    #(HALF/2) rel_scl();
    #(HALF/2) sda_m = 1'b1;
    #HALF;
  endtask
  // Byte out, MSB first, ack bit separate
  task automatic put8(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    put8(b);
    clk_bit(1'b1, ack);
  endtask
  // Byte in; jam holds SDA low to force a collision
  task automatic get(input logic jam, input logic nack,
    output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(!jam, d[i]);
    clk_bit(nack, s);
  endtask
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// Self-checking bench of the serial slave engine
module tb_top;
  import issl_pkg::*;
  logic clk, rstn, scl_o, sda_o, scl_oe_n, sda_oe_n;
  logic scl_m, sda_m, stuck, a;
  logic [7:0] d, wd, own_addr_wdata, buf_wdata, own_address, serial_buffer;
  logic [7:0] second_own_address, address_mask_one, address_mask_two;
  logic ten_bit_mode, stretch_enable, address_hold_enable, data_hold_enable;
  logic start_irq_enable, slave_collision_detect_enable, ack_value_select;
  logic buffer_overwrite_enable, stop_irq_enable;
  logic own_addr_wr, ckp_set, irq_clear, buf_read, buf_write;
  logic ovf_clear, bcl_clear, serial_irq_flag, update_address_flag;
  logic buffer_full_flag, receive_overflow_flag, clock_release_bit;
  logic ack_time_status, master_ack_status, bus_collision_flag;
  logic rw_status, data_status, start_status, stop_status;
  logic [6:0] cfg, pv;
  int n_fail, tests_run;
  // Wired-AND bus with pull-ups
  wire scl_i = scl_oe_n & scl_m;
  wire sda_i = sda_oe_n & sda_m;
  assign {ack_value_select, slave_collision_detect_enable, start_irq_enable,
    data_hold_enable, address_hold_enable, stretch_enable, ten_bit_mode} = cfg;
  assign {bcl_clear, ovf_clear, buf_write, buf_read, irq_clear, ckp_set,
    own_addr_wr} = pv;
  assign own_addr_wdata = wd;
  assign buf_wdata = wd;

  issl_slave issl_slave_inst (.*);
  issl_master_model mst (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_i),
    .sda_w(sda_i), .stuck(stuck));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [6:0] m, input logic [7:0] v);
    @(posedge clk);
    pv <= m;
    wd <= v;
    @(posedge clk);
    pv <= 7'h00;
    #1;
  endtask
  task automatic setc(input logic [6:0] v);
    @(posedge clk);
    cfg <= v;
    #1;
  endtask
  task automatic gap();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_write();
    pulse(7'h01, 8'h44);
    setc(7'h10);
    mst.start();
    gap();
    chk({start_status, serial_irq_flag}, 16'h0003);
    pulse(7'h04, 8'h00);
    mst.send(8'h44, a);
    gap();
    chk({a, rw_status, serial_buffer}, 16'h0044);
    chk({serial_irq_flag, buffer_full_flag}, 16'h0003);
    pulse(7'h0C, 8'h00);
    mst.send(8'h3C, a);
    gap();
    chk({a, data_status, serial_buffer}, 16'h013C);
    mst.send(8'hC3, a);
    gap();
    chk({a, receive_overflow_flag, serial_buffer}, 16'h033C);
    mst.stop();
    gap();
    chk(stop_status, 16'h0001);
    mst.start();
    mst.send(8'h44, a);
    chk(a, 16'h0001);
    mst.stop();
    pulse(7'h2C, 8'h00);
    setc(7'h00);
  endtask
  task automatic t_other();
    mst.start();
    mst.send(8'h46, a);
    gap();
    chk({a, serial_irq_flag, buffer_full_flag, serial_buffer}, 16'h043C);
    mst.start();
    mst.send(8'h58, a);
    gap();
    chk({a, serial_buffer}, 16'h0058);
    pulse(7'h0C, 8'h00);
    mst.stop();
    setc(7'h02);
    mst.start();
    mst.send(8'h44, a);
    gap();
    chk({scl_oe_n, clock_release_bit}, 16'h0000);
    pulse(7'h0E, 8'h00);
    chk(scl_oe_n, 16'h0001);
    mst.stop();
    setc(7'h0C);
  endtask
  task automatic t_hold();
    pulse(7'h04, 8'h00);
    mst.start();
    mst.put8(8'h44);
    gap();
    chk({serial_irq_flag, clock_release_bit, ack_time_status, scl_oe_n},
      16'h000A);
    pulse(7'h0E, 8'h00);
    mst.clk_bit(1'b1, a);
    gap();
    chk({a, serial_irq_flag}, 16'h0001);
    pulse(7'h0C, 8'h00);
    mst.put8(8'h77);
    gap();
    chk({serial_irq_flag, clock_release_bit}, 16'h0002);
    setc(7'h4C);
    pulse(7'h0E, 8'h00);
    mst.clk_bit(1'b1, a);
    gap();
    chk({a, serial_irq_flag}, 16'h0002);
    mst.stop();
    setc(7'h00);
  endtask
  task automatic t_read();
    mst.start();
    mst.send(8'h45, a);
    gap();
    chk({a, rw_status, clock_release_bit, scl_oe_n, serial_buffer},
      16'h0445);
    pulse(7'h0C, 8'h00);
    pulse(7'h10, 8'h4A);
    chk(sda_oe_n, 16'h0000);
    pulse(7'h02, 8'h00);
    mst.get(1'b0, 1'b0, d);
    gap();
    chk({master_ack_status, serial_irq_flag, clock_release_bit, d},
      16'h024A);
    pulse(7'h14, 8'hB6);
    pulse(7'h02, 8'h00);
    mst.get(1'b0, 1'b1, d);
    gap();
    chk({master_ack_status, serial_irq_flag, scl_oe_n, d}, 16'h07B6);
    pulse(7'h04, 8'h00);
    mst.stop();
    gap();
    chk(serial_irq_flag, 16'h0001);
    setc(7'h20);
    mst.start();
    mst.send(8'h45, a);
    gap();
    pulse(7'h0C, 8'h00);
    pulse(7'h10, 8'hA4);
    pulse(7'h02, 8'h00);
    mst.get(1'b1, 1'b1, d);
    gap();
    chk({bus_collision_flag, sda_oe_n}, 16'h0003);
    pulse(7'h4C, 8'h00);
    mst.stop();
    setc(7'h01);
  endtask
  task automatic t_ten();
    pulse(7'h01, 8'hF2);
    mst.start();
    mst.send(8'hF2, a);
    gap();
    chk({a, update_address_flag, scl_oe_n}, 16'h0002);
    pulse(7'h0D, 8'h34);
    chk({update_address_flag, scl_oe_n}, 16'h0001);
    mst.send(8'h34, a);
    gap();
    chk({a, update_address_flag, serial_irq_flag}, 16'h0003);
    pulse(7'h0D, 8'hF2);
    mst.start();
    mst.send(8'hF3, a);
    gap();
    chk({a, rw_status}, 16'h0001);
    pulse(7'h0C, 8'h00);
    pulse(7'h10, 8'h5C);
    pulse(7'h02, 8'h00);
    mst.get(1'b0, 1'b1, d);
    chk(d, 16'h005C);
    mst.stop();
    mst.start();
    mst.send(8'hF3, a);
    chk(a, 16'h0001);
    mst.stop();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    cfg = 7'h00;
    pv = 7'h00;
    wd = 8'h00;
    second_own_address = 8'h5A;
    address_mask_one = 8'hFF;
    address_mask_two = 8'hFD;
    buffer_overwrite_enable = 1'b0;
    stop_irq_enable = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({scl_o, sda_o, clock_release_bit, scl_oe_n, sda_oe_n, own_address},
      16'h0700);
    t_write();
    t_other();
    t_hold();
    t_read();
    t_ten();
    print_verdict();
  end
  // Hung bus ends the run
  always @(posedge stuck) begin
    n_fail++;
    print_verdict();
  end
endmodule
